// ---- include/updown_timer_pkg.sv ----
/*
 * Shared definitions of the 8-bit up/down reload timer: register map,
 * field positions, reset values, prescaler taps and bus carrier types.
 * Assumes a 32-bit APB with byte addresses and one register per word.
 */
`default_nettype none

package updown_timer_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam int          ADDR_W                = 8;
    localparam logic [7:0]  OFF_MODE              = 8'h00; // timer_mode_reg
    localparam logic [7:0]  OFF_COUNT             = 8'h04; // read count, write reload
    localparam logic [7:0]  OFF_CLOCK_STOP        = 8'h08; // clock_stop_reg_1
    localparam logic [7:0]  OFF_IRQ_REQ           = 8'h0c; // interrupt_request_reg_2
    localparam logic [7:0]  OFF_IRQ_EN            = 8'h10; // interrupt_enable_reg_2
    localparam logic [7:0]  OFF_EDGE_SEL          = 8'h14; // edge_select_reg

    // ==========================================================
    // reset values, count limits and step
    localparam logic [7:0]  MODE_RESET            = 8'h18;
    localparam logic [7:0]  CLOCK_STOP_RESET      = 8'hff;
    localparam logic [7:0]  COUNT_RESET           = 8'h00;
    localparam logic [7:0]  COUNT_MAX             = 8'hff;
    localparam logic [7:0]  COUNT_MIN             = 8'h00;
    localparam logic [7:0]  COUNT_STEP            = 8'h01;

    // ==========================================================
    // field positions
    localparam int          MODE_RELOAD_BIT       = 7;
    localparam int          MODE_HWDIR_BIT        = 6;
    localparam int          MODE_SWDIR_BIT        = 5;
    localparam logic [1:0]  MODE_RESERVED_VAL     = 2'h3;
    localparam int          CLOCK_STOP_TIMER_BIT  = 1;
    localparam int          IRQ_FLAG_BIT          = 0;
    localparam int          IRQ_EN_BIT            = 0;
    localparam int          EDGE_SEL_BIT          = 1;

    // ==========================================================
    // clock select codes and prescaler taps (log2 of divide ratio)
    localparam int          N_INT_CLOCKS          = 7;
    localparam int          PRESCALE_W            = 13;
    localparam logic [2:0]  CLKSEL_EXTERNAL       = 3'h7;
    localparam int          TAP_LOG2 [N_INT_CLOCKS] = '{13, 11, 9, 6, 4, 2, 5};

    // ==========================================================
    // bus carrier types
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

`default_nettype wire

// ---- hw/updown_reload_timer8.sv ----
/*
 * 8-bit up/down timer with interval and auto-reload modes, seven internal
 * prescaled clocks or an external event pin, hardware or software count
 * direction, overflow flag and interrupt request, module standby bit.
 * Assumes one 125 MHz clock, an APB master on the same clock, and
 * asynchronous event and direction pins.
 */
// Design decisions made here: the APB slave port and the register addresses.
// Overview of operation
// - 8-bit counter readable anytime without disturbance
// - overflow or underflow sets the flag
// - count reads, reload writes, one address
// - reset clears counter and reload value
// - reload write also loads the counter
// - reload mode reloads counter on wrap
// - reload period spans 1 to 256 clocks
// - interval mode wraps to 00 or FF
// - interrupt request when flag and enable
// - runs as up interval timer after reset
// - clock select: seven prescalers, 111 external
// - hardware direction: pin high up, low down
// - stop bit zero halts timer, resets one
// - reload mode shares clock, direction, interrupt
// - direction bits: 00 up, 01 down, 1x pin
// - edge select bit picks external edge
// - mode bits 4 and 3 read one
`default_nettype none

module updown_reload_timer8
    import updown_timer_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     resetn,
    input  wire apb_req_t apbReq,
    output var apb_rsp_t  apbRsp,
    input  wire logic     eventInputPin,
    input  wire logic     countDirectionPin,
    output logic          intReq
);

    // ==========================================================
    // reset release
    logic [1:0] rstPipe;
    logic       rstSync;

    // async assert, release after two clean edges
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSync = rstPipe[1];

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]            count;
        logic [7:0]            reload;
        logic                  reloadMode;
        logic                  hwDir;
        logic                  swDir;
        logic [2:0]            clkSel;
        logic                  moduleRun;
        logic                  ovfFlag;
        logic                  ovfEnable;
        logic                  edgeRise;
        logic [PRESCALE_W-1:0] prescale;
        logic [2:0]            evtSync;
        logic                  evtLevel;
        logic [2:0]            dirSync;
        logic                  dirLevel;
        logic [31:0]           rdata;
    } state_t;

    state_t s;
    state_t next_s;

    // ==========================================================
    // prescaler taps
    logic [N_INT_CLOCKS-1:0] preTick;

    // a tap fires once per wrap of its low prescaler bits
    generate
        for (genvar i = 0; i < N_INT_CLOCKS; i++)
        begin : g_tap
            assign preTick[i] = &s.prescale[TAP_LOG2[i]-1:0];
        end
    endgenerate

    // ==========================================================
    // pin conditioning and count control
    logic evtAgree;
    logic evtEdge;
    logic dirAgree;
    logic countTick;
    logic countUp;
    logic busWrite;
    logic busSetupRead;
    logic hitMode;
    logic hitCount;
    logic hitStop;
    logic hitReq;
    logic hitEn;
    logic hitEdge;
    logic mapped;
    logic atLimit;

    // only the second and third stages are compared; the first is left alone
    assign evtAgree  = s.evtSync[1] == s.evtSync[2];
    assign evtEdge   = evtAgree && (s.evtSync[2] != s.evtLevel)
                       && (s.evtSync[2] == s.edgeRise);
    assign dirAgree  = s.dirSync[1] == s.dirSync[2];

    // standby simply stops ticks; registers stay reachable
    assign countTick = s.moduleRun
                       && ((s.clkSel == CLKSEL_EXTERNAL) ? evtEdge
                                                         : preTick[s.clkSel]);
    // pin level wins over software bit whenever hardware control is on
    assign countUp   = s.hwDir ? s.dirLevel : !s.swDir;
    assign atLimit   = countUp ? (s.count == COUNT_MAX) : (s.count == COUNT_MIN);

    // address decode
    assign hitMode   = apbReq.paddr == OFF_MODE;
    assign hitCount  = apbReq.paddr == OFF_COUNT;
    assign hitStop   = apbReq.paddr == OFF_CLOCK_STOP;
    assign hitReq    = apbReq.paddr == OFF_IRQ_REQ;
    assign hitEn     = apbReq.paddr == OFF_IRQ_EN;
    assign hitEdge   = apbReq.paddr == OFF_EDGE_SEL;
    assign mapped    = hitMode | hitCount | hitStop | hitReq | hitEn | hitEdge;

    assign busWrite     = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign busSetupRead = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

    // ==========================================================
    // next state
    always_comb
    begin
        next_s = s;

        // free-running prescaler and pin sync stages
        next_s.prescale = s.prescale + PRESCALE_W'(1);
        next_s.evtSync  = {s.evtSync[1:0], eventInputPin};
        next_s.dirSync  = {s.dirSync[1:0], countDirectionPin};
        if (evtAgree)
            next_s.evtLevel = s.evtSync[2];
        if (dirAgree)
            next_s.dirLevel = s.dirSync[2];

        // counting; same path serves both modes
        if (countTick)
        begin
            if (atLimit)
            begin
                next_s.ovfFlag = 1'b1;
                if (s.reloadMode)
                    next_s.count = s.reload;
                else
                    next_s.count = countUp ? COUNT_MIN : COUNT_MAX;
            end
            else if (countUp)
                next_s.count = s.count + COUNT_STEP;
            else
                next_s.count = s.count - COUNT_STEP;
        end

        // register writes; a reload write beats a same-cycle tick
        if (busWrite)
        begin
            if (hitMode)
            begin
                next_s.reloadMode = apbReq.pwdata[MODE_RELOAD_BIT];
                next_s.hwDir      = apbReq.pwdata[MODE_HWDIR_BIT];
                next_s.swDir      = apbReq.pwdata[MODE_SWDIR_BIT];
                next_s.clkSel     = apbReq.pwdata[2:0];
            end
            if (hitCount)
            begin
                next_s.reload = apbReq.pwdata[7:0];
                next_s.count  = apbReq.pwdata[7:0];
            end
            if (hitStop)
                next_s.moduleRun = apbReq.pwdata[CLOCK_STOP_TIMER_BIT];
            // writing 0 clears, but a wrap in the same cycle keeps it set
            if (hitReq && !apbReq.pwdata[IRQ_FLAG_BIT] && !(countTick && atLimit))
                next_s.ovfFlag = 1'b0;
            if (hitEn)
                next_s.ovfEnable = apbReq.pwdata[IRQ_EN_BIT];
            if (hitEdge)
                next_s.edgeRise = apbReq.pwdata[EDGE_SEL_BIT];
        end

        // read data captured in setup; counting is untouched by reads
        if (busSetupRead)
        begin
            next_s.rdata = 32'h0;
            if (hitMode)
                next_s.rdata[7:0] = {s.reloadMode, s.hwDir, s.swDir,
                                     MODE_RESERVED_VAL, s.clkSel};
            if (hitCount)
                next_s.rdata[7:0] = s.count;
            if (hitStop)
            begin
                next_s.rdata[7:0] = CLOCK_STOP_RESET;
                next_s.rdata[CLOCK_STOP_TIMER_BIT] = s.moduleRun;
            end
            if (hitReq)
                next_s.rdata[IRQ_FLAG_BIT] = s.ovfFlag;
            if (hitEn)
                next_s.rdata[IRQ_EN_BIT] = s.ovfEnable;
            if (hitEdge)
                next_s.rdata[EDGE_SEL_BIT] = s.edgeRise;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            s            <= '0;
            s.count      <= COUNT_RESET;
            s.reload     <= COUNT_RESET;
            s.reloadMode <= MODE_RESET[MODE_RELOAD_BIT];
            s.hwDir      <= MODE_RESET[MODE_HWDIR_BIT];
            s.swDir      <= MODE_RESET[MODE_SWDIR_BIT];
            s.clkSel     <= MODE_RESET[2:0];
            s.moduleRun  <= CLOCK_STOP_RESET[CLOCK_STOP_TIMER_BIT];
        end
        else
            s <= next_s;
    end

    // ==========================================================
    // outputs
    // zero-wait slave; unmapped addresses error in the access phase
    assign apbRsp.prdata  = s.rdata;
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
    assign intReq         = s.ovfFlag && s.ovfEnable;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSync);

    logic wrCount;
    logic wrOther;
    assign wrCount = busWrite && hitCount;
    assign wrOther = busWrite && !hitCount;

    reload_write_a: assert property (
        wrCount |=> (s.count == $past(apbReq.pwdata[7:0])) && (s.reload == s.count))
        else $error("reload write did not load counter");

    up_wrap_a: assert property (
        (countTick && countUp && s.count == COUNT_MAX && !s.reloadMode && !wrCount)
        |=> s.count == COUNT_MIN && s.ovfFlag)
        else $error("interval overflow did not wrap to zero");

    down_wrap_a: assert property (
        (countTick && !countUp && s.count == COUNT_MIN && !s.reloadMode && !wrCount)
        |=> s.count == COUNT_MAX && s.ovfFlag)
        else $error("interval underflow did not wrap to ff");

    auto_reload_a: assert property (
        (countTick && atLimit && s.reloadMode && !wrCount)
        |=> s.count == $past(s.reload))
        else $error("reload mode wrap did not load reload value");

    flag_set_a: assert property (
        (countTick && atLimit) |=> s.ovfFlag ##1 s.ovfFlag || $past(busWrite && hitReq))
        else $error("overflow flag lost");

    irq_forward_a: assert property (
        (busWrite && hitEn && apbReq.pwdata[IRQ_EN_BIT] && s.ovfFlag) |=> intReq)
        else $error("enabled overflow raised no request");

    standby_hold_a: assert property (
        (!s.moduleRun && !wrCount)[*2] |-> $stable(s.count))
        else $error("counter moved in module standby");

    reserved_read_a: assert property (
        (busSetupRead && hitMode) |=> s.rdata[4:3] == MODE_RESERVED_VAL)
        else $error("reserved mode bits not read as one");

    hw_up_a: assert property (
        (countTick && s.hwDir && s.dirLevel && s.count != COUNT_MAX && !wrOther && !wrCount)
        |=> s.count == $past(s.count) + COUNT_STEP)
        else $error("pin high did not count up");

    // ==========================================================
    // further checks: reset, direction, bus side effects

    reset_values_a: assert property (
        $rose(rstSync)
        |-> s.count == COUNT_RESET && s.reload == COUNT_RESET && !s.reloadMode && !s.hwDir && !s.swDir)
        else $error("state not at reset values after reset");

    sw_down_a: assert property (
        (countTick && !s.hwDir && s.swDir && s.count != COUNT_MIN && !wrCount)
        |=> s.count == $past(s.count) - COUNT_STEP)
        else $error("software down did not count down");

    hw_down_a: assert property (
        (countTick && s.hwDir && !s.dirLevel && s.count != COUNT_MIN && !wrCount)
        |=> s.count == $past(s.count) - COUNT_STEP)
        else $error("pin low did not count down");

    read_quiet_a: assert property (
        (busSetupRead && hitCount && !countTick)
        |=> s.count == $past(s.count))
        else $error("count read disturbed the counter");

    flag_clear_a: assert property (
        (busWrite && hitReq && !apbReq.pwdata[IRQ_FLAG_BIT] && !(countTick && atLimit))
        |=> !s.ovfFlag)
        else $error("flag clear write ignored");

    mode_write_a: assert property (
        (busWrite && hitMode)
        |=> s.hwDir == $past(apbReq.pwdata[MODE_HWDIR_BIT]) && s.swDir == $past(apbReq.pwdata[MODE_SWDIR_BIT]))
        else $error("direction bits not stored");

    pin_filter_a: assert property (
        (s.evtSync[1] != s.evtSync[2])
        |=> s.evtLevel == $past(s.evtLevel))
        else $error("event level moved while stages disagree");

    tick_only_a: assert property (
        (!countTick && !wrCount)
        |=> $stable(s.count))
        else $error("counter moved without a tick");

    stop_write_a: assert property (
        (busWrite && hitStop)
        |=> s.moduleRun == $past(apbReq.pwdata[CLOCK_STOP_TIMER_BIT]))
        else $error("module stop bit not stored");

    count_read_a: assert property (
        (busSetupRead && hitCount)
        |=> s.rdata[7:0] == $past(s.count))
        else $error("count address did not return live count");

endmodule

`default_nettype wire

// ---- test/event_pin_source.sv ----
/*
 * partner model: external event pin and count direction pin.
 * assumes the bench calls drive() from the clk_sys domain.
 */
`default_nettype none

module event_pin_source (
    input  wire logic clk_sys,
    output logic      eventInputPin,
    output logic      countDirectionPin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // pin levels at time zero
    initial
    begin
        eventInputPin <= 1'b0;
        countDirectionPin <= 1'b1;
    end

    // one level held 6 cycles, beyond the 3-cycle filter
    task automatic drive(input logic evt, input logic dirUp);
        @(posedge clk_sys);
        eventInputPin <= evt;
        countDirectionPin <= dirUp;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

`default_nettype wire

// ---- test/tb_updown_reload_timer8.sv ----
/*
 * self-checking bench of the 8-bit up/down reload timer.
 * assumes zero-wait apb slave and the pin partner model.
 */
`default_nettype none

module tb_updown_reload_timer8
    import updown_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic     clk_sys;
    logic     resetn;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    logic     eventInputPin;
    logic     countDirectionPin;
    logic     intReq;
    logic     lastErr;
    int       num_errors;
    int       num_checks;

    updown_reload_timer8 updown_reload_timer8_inst (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .apbReq           (apbReq),
        .apbRsp           (apbRsp),
        .eventInputPin    (eventInputPin),
        .countDirectionPin(countDirectionPin),
        .intReq           (intReq)
    );

    event_pin_source event_pin_source_inst (
        .clk_sys          (clk_sys),
        .eventInputPin    (eventInputPin),
        .countDirectionPin(countDirectionPin)
    );

    // ==========================================================
    // clock, 8 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
        r = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(n, r, {24'h0, e});
    endtask

    // full event pulses; falling edge selected after reset
    task automatic pulse(input int n, input logic dirUp);
        repeat (n)
        begin
            event_pin_source_inst.drive(1'b1, dirUp);
            event_pin_source_inst.drive(1'b0, dirUp);
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset();
        rdc("mode", OFF_MODE, MODE_RESET);
        rdc("count", OFF_COUNT, COUNT_RESET);
        rdc("clkstop", OFF_CLOCK_STOP, CLOCK_STOP_RESET);
        chk("intReq", intReq, 0);
    endtask

    task automatic test_up_wrap();
        wr(OFF_MODE, 8'h07);
        rdc("mode rsv", OFF_MODE, 8'h1f);
        wr(OFF_COUNT, 8'hfe);
        rdc("load", OFF_COUNT, 8'hfe);
        pulse(2, 1'b1);
        rdc("wrap up", OFF_COUNT, 8'h00);
        rdc("flag", OFF_IRQ_REQ, 8'h01);
        wr(OFF_IRQ_EN, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk("irq on", intReq, 1);
        wr(OFF_IRQ_EN, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk("irq mask", intReq, 0);
        wr(OFF_IRQ_REQ, 8'h00);
        rdc("flag clr", OFF_IRQ_REQ, 8'h00);
    endtask

    task automatic test_down_wrap();
        wr(OFF_MODE, 8'h27);
        wr(OFF_COUNT, 8'h01);
        pulse(2, 1'b1);
        rdc("wrap dn", OFF_COUNT, 8'hff);
        rdc("uflag", OFF_IRQ_REQ, 8'h01);
        wr(OFF_IRQ_REQ, 8'h00);
    endtask

    task automatic test_reload();
        wr(OFF_MODE, 8'h87);
        wr(OFF_COUNT, 8'hfd);
        pulse(2, 1'b1);
        rdc("pre", OFF_COUNT, 8'hff);
        rdc("noflag", OFF_IRQ_REQ, 8'h00);
        pulse(1, 1'b1);
        rdc("reload", OFF_COUNT, 8'hfd);
        rdc("rflag", OFF_IRQ_REQ, 8'h01);
        wr(OFF_IRQ_REQ, 8'h00);
        wr(OFF_COUNT, 8'hff);
        pulse(1, 1'b1);
        rdc("period1", OFF_COUNT, 8'hff);
        rdc("p1flag", OFF_IRQ_REQ, 8'h01);
        wr(OFF_IRQ_REQ, 8'h00);
    endtask

    task automatic test_hwdir();
        wr(OFF_MODE, 8'hc7);
        wr(OFF_COUNT, 8'h10);
        pulse(1, 1'b0);
        rdc("pin low", OFF_COUNT, 8'h0f);
        pulse(2, 1'b1);
        rdc("pin high", OFF_COUNT, 8'h11);
    endtask

    task automatic test_edge();
        wr(OFF_MODE, 8'h07);
        wr(OFF_EDGE_SEL, 8'h02);
        wr(OFF_COUNT, 8'h20);
        event_pin_source_inst.drive(1'b1, 1'b1);
        rdc("rise", OFF_COUNT, 8'h21);
        event_pin_source_inst.drive(1'b0, 1'b1);
        rdc("fall ign", OFF_COUNT, 8'h21);
        wr(OFF_EDGE_SEL, 8'h00);
        event_pin_source_inst.drive(1'b1, 1'b1);
        rdc("rise ign", OFF_COUNT, 8'h21);
        event_pin_source_inst.drive(1'b0, 1'b1);
        rdc("fall", OFF_COUNT, 8'h22);
    endtask

    task automatic test_standby();
        wr(OFF_CLOCK_STOP, 8'hfd);
        rdc("stop rd", OFF_CLOCK_STOP, 8'hfd);
        pulse(2, 1'b1);
        rdc("frozen", OFF_COUNT, 8'h22);
        wr(OFF_COUNT, 8'h40);
        wr(OFF_CLOCK_STOP, 8'hff);
        pulse(1, 1'b1);
        rdc("resume", OFF_COUNT, 8'h41);
    endtask

    // mid-run reset; reload value seen through a reload-mode underflow
    task automatic test_midreset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdc("rst count", OFF_COUNT, COUNT_RESET);
        rdc("rst mode", OFF_MODE, MODE_RESET);
        wr(OFF_MODE, 8'ha7);
        pulse(1, 1'b1);
        rdc("rst reload", OFF_COUNT, COUNT_RESET);
        rdc("rst flag", OFF_IRQ_REQ, 8'h01);
        wr(OFF_IRQ_REQ, 8'h00);
    endtask

    task automatic test_misc();
        logic [31:0] r;
        apb(1'b1, 8'h18, 32'h5a, r);
        chk("unm werr", lastErr, 1);
        apb(1'b0, 8'h18, 32'h0, r);
        chk("unm rd", r, 0);
        chk("unm rerr", lastErr, 1);
        wr(OFF_MODE, 8'h05);
        wr(OFF_COUNT, 8'h00);
        repeat (40) @(posedge clk_sys);
        apb(1'b0, OFF_COUNT, 32'h0, r);
        chk("div4", (r >= 32'd9 && r <= 32'd12), 1);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        num_errors = 0;
        num_checks = 0;
        lastErr = 1'b0;
        apbReq <= '0;
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_reset();
        test_up_wrap();
        test_down_wrap();
        test_reload();
        test_hwdir();
        test_edge();
        test_standby();
        test_midreset();
        test_misc();
        end_of_test();
    end

    // run needs about 470 cycles; generous margin
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
